/* File: logic/emab_top.sv */
/*
 Bus-master arbitration and burst control with its dual-clock write FIFO.
 Assumes the local controller sits on ref_clk and the EISA side on bclk;
 pad logic resolves three-state pins from the enables given here.
*/
`timescale 1ns/1ps
`default_nettype none
`include "emab_defs.svh"

// ----------------------------------------------------------------------------
// Dual-clock FIFO, gray-coded pointers
// ----------------------------------------------------------------------------
module emab_fifo #(
    parameter int W     = 67,
    parameter int DEPTH = 32,
    parameter int AW    = $clog2(DEPTH)
) (
    input  wire logic         wclk,
    input  wire logic         wrst_n,
    input  wire logic         w_hold,
    input  wire logic         w_valid,
    input  wire logic [W-1:0] w_data,
    output logic              w_ready,
    input  wire logic         rclk,
    input  wire logic         rrst_n,
    input  wire logic         r_ready,
    output logic              r_valid,
    output logic [W-1:0]      r_data
);
    // DEPTH must be a power of two for the gray full test to hold
    logic [W-1:0]  mem [DEPTH];
    logic [AW:0]   wbin_r, wbin_nxt, wgray_r, wgray_nxt, rq1_r, rq2_r;
    logic [AW:0]   rbin_r, rbin_nxt, rgray_r, rgray_nxt, wq1_r, wq2_r;
    logic          ready_r, ready_nxt, valid_r, valid_nxt, push, pop;

    function automatic logic [AW:0] to_gray(input logic [AW:0] b);
        to_gray = b ^ (b >> 1);
    endfunction

    always_comb begin
        push      = w_valid & ready_r;
        wbin_nxt  = wbin_r + {{AW{1'b0}}, push};
        wgray_nxt = to_gray(wbin_nxt);
        ready_nxt = ~w_hold & (wgray_nxt != {~rq2_r[AW:AW-1], rq2_r[AW-2:0]});
        pop       = r_ready & valid_r;
        rbin_nxt  = rbin_r + {{AW{1'b0}}, pop};
        rgray_nxt = to_gray(rbin_nxt);
        valid_nxt = (rgray_nxt != wq2_r);
    end

    always_ff @(posedge wclk or negedge wrst_n) begin
        if (!wrst_n) begin
            wbin_r  <= '0;
            wgray_r <= '0;
            rq1_r   <= '0;
            rq2_r   <= '0;
            ready_r <= 1'b0;
        end else begin
            wbin_r  <= wbin_nxt;
            wgray_r <= wgray_nxt;
            rq1_r   <= rgray_r;
            rq2_r   <= rq1_r;
            ready_r <= ready_nxt;
        end
    end

    always_ff @(posedge wclk) begin
        if (push) begin
            mem[wbin_r[AW-1:0]] <= w_data;
        end
    end

    always_ff @(posedge rclk or negedge rrst_n) begin
        if (!rrst_n) begin
            rbin_r  <= '0;
            rgray_r <= '0;
            wq1_r   <= '0;
            wq2_r   <= '0;
            valid_r <= 1'b0;
        end else begin
            rbin_r  <= rbin_nxt;
            rgray_r <= rgray_nxt;
            wq1_r   <= wgray_r;
            wq2_r   <= wq1_r;
            valid_r <= valid_nxt;
        end
    end

    assign w_ready = ready_r;
    assign r_valid = valid_r;
    assign r_data  = mem[rbin_r[AW-1:0]];
endmodule // emab_fifo

// ----------------------------------------------------------------------------
// Top: local side on ref_clk, EISA side on bclk
// ----------------------------------------------------------------------------
module emab_top
    import emab_pkg::*;
#(
    parameter int DEPTH = 32
) (
    input  wire logic        ref_clk,
    input  wire logic        resetn,
    input  wire logic        bclk,
    input  wire logic        bus_reset_input,
    input  wire logic        cfg_burst_en,
    input  wire logic        cfg_hold_long,
    input  wire logic        local_bus_req,
    output logic             local_bus_grant,
    input  wire logic        wr_valid,
    input  wire logic [31:1] wr_addr,
    input  wire logic [31:0] wr_data,
    input  wire logic [3:0]  wr_be,
    output logic             wr_ready,
    input  wire logic        mak_n,
    input  wire logic        slburst_n,
    input  wire logic        ex32_n,
    input  wire logic        exrdy,
    output logic             mreq_n,
    output logic             msburst_n,
    output logic             cmd_n,
    input  wire logic [31:2] la_in,
    output logic [31:2]      la_out,
    output logic             la_oe,
    input  wire logic        start_n_in,
    output logic             start_n_out,
    output logic             start_n_oe,
    input  wire logic [3:0]  be_n_in,
    output logic [3:0]       be_n_out,
    output logic             be_n_oe,
    input  wire logic [31:0] d_in,
    output logic [31:0]      d_out,
    output logic             d_oe
);
    localparam int W = 67;

    // Read-back of own pins is not needed while this block is master
    logic        unused_pins;
    assign unused_pins = ^{la_in, start_n_in, be_n_in, d_in};

    // ------------------------------------------------------------------------
    // Local side: bus reset and grant arrive from other domains
    // ------------------------------------------------------------------------
    logic [1:0]  rs1_r, rs2_r, rs1_nxt, rs2_nxt;
    logic        grant_b_r;

    always_comb begin
        rs1_nxt = {bus_reset_input, grant_b_r};
        rs2_nxt = rs1_r;
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            rs1_r <= 2'h0;
            rs2_r <= 2'h0;
        end else begin
            rs1_r <= rs1_nxt;
            rs2_r <= rs2_nxt;
        end
    end

    // Grant falls under bus reset only after the link side clears it and two ref_clk stages pass it back
    assign local_bus_grant = rs2_r[0];

    // ------------------------------------------------------------------------
    // Write FIFO between the domains
    // ------------------------------------------------------------------------
    logic         f_valid, f_pop;
    logic [W-1:0] f_data;

    emab_fifo #(.W(W), .DEPTH(DEPTH)) u_fifo (
        .wclk    (ref_clk),
        .wrst_n  (resetn),
        .w_hold  (rs2_r[1]),
        .w_valid (wr_valid),
        .w_data  ({wr_addr, wr_data, wr_be}),
        .w_ready (wr_ready),
        .rclk    (bclk),
        .rrst_n  (resetn),
        .r_ready (f_pop),
        .r_valid (f_valid),
        .r_data  (f_data)
    );

    // ------------------------------------------------------------------------
    // Link side
    // ------------------------------------------------------------------------
    logic [7:0]  bs1_r, bs2_r;
    emab_state_t st_r, st_nxt;
    logic        mreq_n_r, mreq_n_nxt, grant_b_nxt, la_oe_r, la_oe_nxt;
    logic [31:2] la_r, la_nxt;
    logic        start_n_r, start_n_nxt, start_oe_r, start_oe_nxt;
    logic [3:0]  be_n_r, be_n_nxt;
    logic        be_oe_r, be_oe_nxt, d_oe_r, d_oe_nxt;
    logic [31:0] d_r, d_nxt;
    logic        cmd_n_r, cmd_n_nxt, msb_n_r, msb_n_nxt;
    logic        burst_r, burst_nxt, cand_r, cand_nxt, first_r, first_nxt;
    logic        pre_r, pre_nxt, rdy_d_r;
    logic [5:0]  cnt_r, cnt_nxt;
    logic [31:1] c_addr;
    logic [31:0] c_data;
    logic [3:0]  c_be;
    logic        brst, req_s, rdy_rise, contig;

    function automatic logic page_edge(input logic [31:2] a);
        page_edge = (a[`EMAB_PAGE_MSB:`EMAB_PAGE_LSB] == '0);
    endfunction

    always_comb begin
        brst     = bs2_r[`EMAB_BS_BRST];
        req_s    = bs2_r[`EMAB_BS_REQ];
        rdy_rise = bs2_r[`EMAB_BS_RDY] & ~rdy_d_r;
        c_addr   = f_data[66:36];
        c_data   = f_data[35:4];
        c_be     = f_data[3:0];
        contig   = (c_addr[31:2] == la_r + 30'h0000_0001) & ~c_addr[1];
        st_nxt       = st_r;
        mreq_n_nxt   = mreq_n_r;
        grant_b_nxt  = grant_b_r;
        la_nxt       = la_r;
        la_oe_nxt    = la_oe_r;
        start_n_nxt  = start_n_r;
        start_oe_nxt = start_oe_r;
        be_n_nxt     = be_n_r;
        be_oe_nxt    = be_oe_r;
        d_nxt        = d_r;
        d_oe_nxt     = d_oe_r;
        cmd_n_nxt    = cmd_n_r;
        msb_n_nxt    = msb_n_r;
        burst_nxt    = burst_r;
        cand_nxt     = cand_r;
        first_nxt    = first_r;
        pre_nxt      = pre_r;
        cnt_nxt      = cnt_r;
        f_pop        = 1'b0;
        case (st_r)
            EMAB_IDLE: begin
                if (req_s) begin
                    mreq_n_nxt = 1'b0;
                    st_nxt     = EMAB_REQ;
                end
            end
            EMAB_REQ: begin
                if (!req_s) begin
                    mreq_n_nxt = 1'b1;
                    st_nxt     = EMAB_IDLE;
                end else if (!bs2_r[`EMAB_BS_MAK]) begin
                    grant_b_nxt = 1'b1;
                    la_oe_nxt   = 1'b1;
                    st_nxt      = EMAB_OWN;
                end
            end
            EMAB_OWN: begin
                if (!req_s) begin
                    st_nxt = EMAB_REL;
                end else if (grant_b_r && f_valid) begin
                    la_nxt       = c_addr[31:2];
                    be_n_nxt     = ~c_be;
                    d_nxt        = c_data;
                    start_n_nxt  = 1'b0;
                    start_oe_nxt = 1'b1;
                    be_oe_nxt    = 1'b1;
                    d_oe_nxt     = 1'b1;
                    // Burst candidate: enabled, aligned, full width, off the page edge
                    cand_nxt     = bs2_r[`EMAB_BS_BEN] & ~c_addr[1]
                                 & (c_be == `EMAB_BE_ALL)
                                 & ~page_edge(c_addr[31:2]);
                    st_nxt       = EMAB_START;
                end
            end
            EMAB_START: begin
                start_n_nxt = 1'b1;
                cmd_n_nxt   = 1'b0;
                first_nxt   = 1'b1;
                st_nxt      = EMAB_CMD;
            end
            EMAB_CMD: begin
                if (first_r) begin
                    first_nxt = 1'b0;
                    if (bs2_r[`EMAB_BS_EX32]) begin
                        // Mismatched width: let the system board finish the cycle
                        start_oe_nxt = 1'b0;
                        be_oe_nxt    = 1'b0;
                        d_oe_nxt     = 1'b0;
                        cmd_n_nxt    = 1'b1;
                        st_nxt       = EMAB_BACKOFF;
                    end else begin
                        burst_nxt = cand_r & ~bs2_r[`EMAB_BS_SLB];
                        msb_n_nxt = ~(cand_r & ~bs2_r[`EMAB_BS_SLB]);
                    end
                end else if (rdy_rise) begin
                    f_pop  = 1'b1;
                    st_nxt = EMAB_NEXT;
                end
            end
            EMAB_NEXT: begin
                // Word under the FIFO head is the next one after the pop
                if (burst_r && f_valid && contig && grant_b_r && req_s
                        && (c_be == `EMAB_BE_ALL) && !page_edge(c_addr[31:2])) begin
                    la_nxt = c_addr[31:2];
                    be_n_nxt = ~c_be;
                    d_nxt  = c_data;
                    st_nxt = EMAB_CMD;
                end else begin
                    cmd_n_nxt    = 1'b1;
                    msb_n_nxt    = 1'b1;
                    burst_nxt    = 1'b0;
                    start_oe_nxt = 1'b0;
                    be_oe_nxt    = 1'b0;
                    d_oe_nxt     = 1'b0;
                    st_nxt       = EMAB_OWN;
                end
            end
            EMAB_BACKOFF: begin
                if (rdy_rise) begin
                    f_pop  = 1'b1;
                    st_nxt = EMAB_OWN;
                end
            end
            EMAB_REL: begin
                grant_b_nxt = 1'b0;
                mreq_n_nxt  = 1'b1;
                la_oe_nxt   = 1'b0;
                pre_nxt     = 1'b0;
                st_nxt      = EMAB_IDLE;
            end
            default: begin
                st_nxt = EMAB_IDLE;
            end
        endcase
        // Preemption hold runs beside the transfer sequencer
        if (pre_r) begin
            if (cnt_r != 6'h00) begin
                cnt_nxt = cnt_r - 6'h01;
            end else begin
                grant_b_nxt = 1'b0;
                mreq_n_nxt  = 1'b1;
                pre_nxt     = 1'b0;
            end
        end else if (grant_b_r && bs2_r[`EMAB_BS_MAK] && st_r != EMAB_REL) begin
            pre_nxt = 1'b1;
            cnt_nxt = bs2_r[`EMAB_BS_LONG] ? `EMAB_HOLD_LONG - 6'h01
                                            : `EMAB_HOLD_SHORT - 6'h01;
        end
        if (brst) begin
            st_nxt       = EMAB_IDLE;
            mreq_n_nxt   = 1'b1;
            grant_b_nxt  = 1'b0;
            la_oe_nxt    = 1'b0;
            start_n_nxt  = 1'b1;
            start_oe_nxt = 1'b0;
            be_oe_nxt    = 1'b0;
            d_oe_nxt     = 1'b0;
            cmd_n_nxt    = 1'b1;
            msb_n_nxt    = 1'b1;
            burst_nxt    = 1'b0;
            pre_nxt      = 1'b0;
            f_pop        = f_valid;  // Queued words are discarded
        end
    end

    always_ff @(posedge bclk or negedge resetn) begin
        if (!resetn) begin
            bs1_r      <= `EMAB_BS_RST;
            bs2_r      <= `EMAB_BS_RST;
            rdy_d_r    <= 1'b0;
            st_r       <= EMAB_IDLE;
            mreq_n_r   <= 1'b1;
            grant_b_r  <= 1'b0;
            la_r       <= '0;
            la_oe_r    <= 1'b0;
            start_n_r  <= 1'b1;
            start_oe_r <= 1'b0;
            be_n_r     <= 4'hf;
            be_oe_r    <= 1'b0;
            d_r        <= '0;
            d_oe_r     <= 1'b0;
            cmd_n_r    <= 1'b1;
            msb_n_r    <= 1'b1;
            burst_r    <= 1'b0;
            cand_r     <= 1'b0;
            first_r    <= 1'b0;
            pre_r      <= 1'b0;
            cnt_r      <= 6'h00;
        end else begin
            bs1_r      <= {bus_reset_input, cfg_burst_en, cfg_hold_long, local_bus_req,
                           mak_n, slburst_n, ex32_n, exrdy};
            bs2_r      <= bs1_r;
            rdy_d_r    <= bs2_r[`EMAB_BS_RDY];
            st_r       <= st_nxt;
            mreq_n_r   <= mreq_n_nxt;
            grant_b_r  <= grant_b_nxt;
            la_r       <= la_nxt;
            la_oe_r    <= la_oe_nxt;
            start_n_r  <= start_n_nxt;
            start_oe_r <= start_oe_nxt;
            be_n_r     <= be_n_nxt;
            be_oe_r    <= be_oe_nxt;
            d_r        <= d_nxt;
            d_oe_r     <= d_oe_nxt;
            cmd_n_r    <= cmd_n_nxt;
            msb_n_r    <= msb_n_nxt;
            burst_r    <= burst_nxt;
            cand_r     <= cand_nxt;
            first_r    <= first_nxt;
            pre_r      <= pre_nxt;
            cnt_r      <= cnt_nxt;
        end
    end

    assign mreq_n      = mreq_n_r;
    assign msburst_n   = msb_n_r;
    assign cmd_n       = cmd_n_r;
    assign la_out      = la_r;
    assign la_oe       = la_oe_r;
    assign start_n_out = start_n_r;
    assign start_n_oe  = start_oe_r;
    assign be_n_out    = be_n_r;
    assign be_n_oe     = be_oe_r;
    assign d_out       = d_r;
    assign d_oe        = d_oe_r;
endmodule // emab_top

`default_nettype wire

/* File: logic/emab_defs.svh */
/*
 Constants for the bus-master arbitration and burst block: hold counts,
 page and alignment fields, reset value of the BCLK synchroniser chain.
 Assumes it is included by its bare name wherever the block's code needs it.
*/
// Function
// - Request seen: assert master request, await acknowledge
// - Acknowledge seen: grant local side, enable address
// - Preempted: hold 55 or 23 BCLKs, drop grant
// - Burst only when burst enable is configured
// - Burst needs aligned start, contiguous following addresses
// - Burst only if slave answers burst capable
// - Burst only at full 32-bit width
// - Width answer inactive means non-burst transfer
// - Width mismatch: float strobe, enables and data
// - No burst start on 1K page boundary
// - Leave burst when address reaches 1K boundary
// - Drive master burst while bursting
// - Bus reset clears logic, aborts any ownership
`ifndef EMAB_DEFS_SVH
`define EMAB_DEFS_SVH

// ----------------------------------------------------------------------------
// Preemption hold, counted in BCLK periods
// ----------------------------------------------------------------------------
`define EMAB_HOLD_LONG   6'h37
`define EMAB_HOLD_SHORT  6'h17

// ----------------------------------------------------------------------------
// Address fields
// ----------------------------------------------------------------------------
`define EMAB_PAGE_MSB    9
`define EMAB_PAGE_LSB    2
`define EMAB_BE_ALL      4'hf

// ----------------------------------------------------------------------------
// Synchroniser layout on BCLK: brst, burst_en, hold_long, req, mak_n,
// slburst_n, ex32_n, exrdy (bit 7 down to bit 0)
// ----------------------------------------------------------------------------
`define EMAB_BS_BRST     7
`define EMAB_BS_BEN      6
`define EMAB_BS_LONG     5
`define EMAB_BS_REQ      4
`define EMAB_BS_MAK      3
`define EMAB_BS_SLB      2
`define EMAB_BS_EX32     1
`define EMAB_BS_RDY      0
`define EMAB_BS_RST      8'h0e

`endif

/* File: logic/emab_pkg.sv */
/*
 Types shared by the arbitration and burst block.
 Assumes the constants header is compiled alongside.
*/
package emab_pkg;

    // ------------------------------------------------------------------------
    // Link-side sequencer states
    // ------------------------------------------------------------------------
    typedef enum logic [2:0] {
        EMAB_IDLE,
        EMAB_REQ,
        EMAB_OWN,
        EMAB_START,
        EMAB_CMD,
        EMAB_NEXT,
        EMAB_BACKOFF,
        EMAB_REL
    } emab_state_t;

endpackage

/* File: test/emab_chk.sv */
/* Link-side checker for emab_top.
   Assumes it is bound into emab_top; all watched signals on bclk. */
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------------------
// Checker
// ----------------------------------------------------------------------------
module emab_chk (
    input wire logic        bclk,
    input wire logic        resetn,
    input wire logic        bus_reset_input,
    input wire logic        cfg_burst_en,
    input wire logic        cfg_hold_long,
    input wire logic        local_bus_req,
    input wire logic        mak_n,
    input wire logic        slburst_n,
    input wire logic        ex32_n,
    input wire logic        mreq_n,
    input wire logic        msburst_n,
    input wire logic        cmd_n,
    input wire logic [31:2] la_out,
    input wire logic        la_oe,
    input wire logic        start_n_out,
    input wire logic        start_n_oe,
    input wire logic [3:0]  be_n_out,
    input wire logic        be_n_oe,
    input wire logic        d_oe
);
    default clocking cb @(posedge bclk); endclocking
    default disable iff (!resetn || bus_reset_input);
    req_first_a: assert property ($fell(mreq_n) |-> $past(local_bus_req, 3))
        else $error("master request without local request");
    grant_mreq_a: assert property ($rose(la_oe) |-> !mreq_n)
        else $error("address enabled without ownership");
    burst_cond_a: assert property ($fell(msburst_n) |-> $past(cfg_burst_en, 3)
        && !$past(slburst_n, 3) && !$past(ex32_n, 3)) else $error("burst not allowed");
    burst_width_a: assert property (!msburst_n |-> !cmd_n && be_n_out == 4'h0)
        else $error("burst outside full width command");
    burst_page_a: assert property (!msburst_n |-> la_out[9:2] != 8'h00)
        else $error("burst on page boundary");
    start_pulse_a: assert property ($fell(start_n_out) |-> start_n_oe && la_oe ##1 start_n_out)
        else $error("start strobe not one cycle");
    backoff_a: assert property (($rose(cmd_n) && $past(ex32_n, 3))
        |-> !d_oe && !be_n_oe && !start_n_oe) else $error("no back-off on mismatch");
    hold_long_a: assert property (($rose(mak_n) && !mreq_n && cfg_hold_long)
        |-> ##53 !mreq_n ##[1:8] mreq_n) else $error("long hold wrong");
    hold_short_a: assert property (($rose(mak_n) && !mreq_n && !cfg_hold_long)
        |-> ##21 !mreq_n ##[1:8] mreq_n) else $error("short hold wrong");
    release_a: assert property (($fell(local_bus_req) && !mreq_n) |-> ##[1:60] mreq_n)
        else $error("bus not released");
endmodule // emab_chk

bind emab_top emab_chk chk_u (.bclk, .resetn, .bus_reset_input, .cfg_burst_en, .cfg_hold_long,
    .local_bus_req, .mak_n, .slburst_n, .ex32_n, .mreq_n, .msburst_n, .cmd_n, .la_out,
    .la_oe, .start_n_out, .start_n_oe, .be_n_out, .be_n_oe, .d_oe);
`default_nettype wire

/* File: test/emab_arb_model.sv */
/* Arbiter and addressed slave on the link side.
   Assumes bench controls other than preempt change only while the bus is not owned. */
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------------------
// Partner model
// ----------------------------------------------------------------------------
module emab_arb_model (
    input  wire logic bclk,
    input  wire logic resetn,
    input  wire logic mreq_n,
    input  wire logic preempt,
    input  wire logic no_burst,
    input  wire logic ex32_bad,
    input  wire logic slow,
    output logic      mak_n,
    output logic      slburst_n,
    output logic      ex32_n,
    output logic      exrdy
);
    logic [2:0] cnt_r;
    logic       last;
    // Lines are pulled up while another master owns the bus
    assign slburst_n = mreq_n | no_burst;
    assign ex32_n    = mreq_n | ex32_bad;
    assign last      = (cnt_r == {slow, 2'b10});
    always_ff @(posedge bclk or negedge resetn) begin
        if (!resetn) begin
            mak_n <= 1'b1;
            cnt_r <= 3'h0;
            exrdy <= 1'b1;
        end else begin
            mak_n <= mreq_n | preempt;
            cnt_r <= (mreq_n || last) ? 3'h0 : cnt_r + 3'h1;
            exrdy <= mreq_n | last;
        end
    end
endmodule // emab_arb_model
`default_nettype wire

/* File: test/emab_top_test.sv */
/* Self-checking bench for emab_top with the link partner model.
   Assumes the checker file is compiled too; pads read back their outputs. */
`timescale 1ns/1ps
`default_nettype none
module emab_top_test;
    logic ref_clk = 0, bclk = 0, resetn = 0, bus_reset_input = 0;
    logic cfg_burst_en = 0, cfg_hold_long = 0, local_bus_req = 0, wr_valid = 0;
    logic [31:1] wr_addr = '0;
    logic [31:0] wr_data = '0;
    logic [3:0]  wr_be = '0;
    logic preempt = 0, no_burst = 0, ex32_bad = 0, slow = 0, cmd_q = 1;
    logic local_bus_grant, wr_ready, mak_n, slburst_n, ex32_n, exrdy, mreq_n, msburst_n;
    logic cmd_n, la_oe, start_n_out, start_n_oe, be_n_oe, d_oe, msb_q;
    logic [31:2] la_out, la_q;
    logic [3:0]  be_n_out;
    logic [31:0] d_out;
    logic [65:0] exp_q[$];
    int fails = 0, n_tests = 0, bursts = 0, cyc = 0;

    initial forever #4 ref_clk = ~ref_clk;
    initial begin
        #1.3;
        forever #3 bclk = ~bclk;
    end

    emab_top #(.DEPTH(32)) dut_u (.ref_clk, .resetn, .bclk, .bus_reset_input, .cfg_burst_en,
        .cfg_hold_long, .local_bus_req, .local_bus_grant, .wr_valid, .wr_addr, .wr_data,
        .wr_be, .wr_ready, .mak_n, .slburst_n, .ex32_n, .exrdy, .mreq_n, .msburst_n, .cmd_n,
        .la_in(la_out), .la_out, .la_oe, .start_n_in(start_n_out), .start_n_out, .start_n_oe,
        .be_n_in(be_n_out), .be_n_out, .be_n_oe, .d_in(d_out), .d_out, .d_oe);
    emab_arb_model arb_u (.bclk, .resetn, .mreq_n, .preempt, .no_burst, .ex32_bad, .slow,
        .mak_n, .slburst_n, .ex32_n, .exrdy);

    task automatic wrap_up();
        if (fails == 0 && n_tests > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    task automatic check(input logic [65:0] seen, input logic [65:0] exp);
        n_tests++;
        if (seen !== exp) begin
            fails++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    // ------------------------------------------------------------------------
    // Watcher: one data phase per new address while the command is low
    // ------------------------------------------------------------------------
    always @(negedge bclk) begin
        if (!cmd_n && d_oe && (cmd_q || la_out != la_q)) begin
            if (exp_q.size() > 0)
                check({la_out, be_n_out, d_out}, exp_q.pop_front());
            else
                check(66'h0, 66'h1);
        end
        if (msb_q && !msburst_n)
            bursts++;
        cmd_q = cmd_n;
        la_q = la_out;
        msb_q = msburst_n;
    end

    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 60000) begin
            fails++;
            wrap_up();
        end
    end

    task automatic push(input logic [31:0] a, input logic [3:0] be, output bit ok);
        logic [31:0] d;
        d = $urandom();
        @(negedge ref_clk);
        wr_valid = 1;
        wr_addr = a[31:1];
        wr_data = d;
        wr_be = be;
        ok = (wr_ready === 1'b1);
        @(posedge ref_clk);
        if (ok)
            exp_q.push_back({a[31:2], ~be, d});
        @(negedge ref_clk);
        wr_valid = 0;
    endtask

    task automatic grab();
        int i;
        @(negedge ref_clk);
        local_bus_req = 1;
        for (i = 0; i < 300 && local_bus_grant !== 1'b1; i++)
            @(negedge ref_clk);
        check({65'h0, local_bus_grant}, 66'h1);
    endtask

    // Bursts stay inside one page unless the scenario picks the base itself
    function automatic logic [31:0] rnd();
        return ($urandom() & 32'hffff_fc00) | 32'h0000_0040;
    endfunction

    task automatic run(input logic ben, ex, nb, sl, input int n, input logic [31:0] base,
                       input logic [3:0] be, input int expb);
        bit ok;
        int i, acc;
        @(negedge ref_clk);
        cfg_burst_en = ben;
        ex32_bad = ex;
        no_burst = nb;
        slow = sl;
        bursts = 0;
        acc = 0;
        for (i = 0; i < n; i++) begin
            push(base + 4 * i, be, ok);
            acc += ok;
        end
        grab();
        for (i = 0; i < 3000 && exp_q.size() > 0; i++)
            @(negedge ref_clk);
        check(66'(exp_q.size()), 66'h0);
        repeat (60) @(negedge ref_clk);
        local_bus_req = 0;
        repeat (80) @(negedge ref_clk);
        check({64'h0, local_bus_grant, mreq_n}, 66'h1);
        check(66'(bursts != 0), 66'(expb));
        if (n > 32)
            check(66'(acc), 66'h20);
    endtask

    initial begin
        int h, cnt;
        void'($urandom(85050));
        repeat (6) @(posedge ref_clk);
        @(negedge ref_clk);
        resetn = 1;
        repeat (4) @(negedge ref_clk);
        run(0, 0, 0, 1, 40, rnd(), 4'hf, 0);
        run(1, 0, 0, 1, 6, rnd(), 4'hf, 1);
        run(1, 0, 1, 0, 4, rnd(), 4'hf, 0);
        run(1, 1, 0, 0, 3, rnd(), 4'hf, 0);
        run(1, 0, 0, 0, 4, rnd(), 4'h3, 0);
        run(1, 0, 0, 0, 4, rnd() | 32'h0000_0002, 4'hf, 0);
        run(1, 0, 0, 0, 6, rnd() | 32'h0000_03b8, 4'hf, 1);
        for (h = 0; h < 2; h++) begin
            cfg_hold_long = h[0];
            grab();
            preempt = 1;
            for (cnt = 0; cnt < 200 && mreq_n !== 1'b1; cnt++)
                @(negedge bclk);
            check(66'(cnt >= (h ? 55 : 23) && cnt <= (h ? 65 : 33)), 66'h1);
            // Local side lets go well inside 9 BCLKs of losing its grant
            repeat (4) @(negedge ref_clk);
            check({64'h0, local_bus_grant, mreq_n}, 66'h1);
            local_bus_req = 0;
            preempt = 0;
            repeat (20) @(negedge ref_clk);
        end
        grab();
        bus_reset_input = 1;
        repeat (10) @(negedge ref_clk);
        check({63'h0, local_bus_grant, mreq_n, wr_ready}, 66'h2);
        bus_reset_input = 0;
        local_bus_req = 0;
        repeat (20) @(negedge ref_clk);
        run(0, 0, 0, 0, 2, rnd(), 4'hf, 0);
        wrap_up();
    end
endmodule // emab_top_test
`default_nettype wire
